// ===== src/tcf_timer_ctrl.sv
// Function
// - Control flags bitwise accessible, bits 7..0 ordered
// - Mode register written only as whole byte
// - Overflow sets flag; vectoring clears it
// - Mode 00 gives 13-bit timer
// - Mode 01 gives full 16-bit counter
// - Mode 10 gives 8-bit auto-reload counter
// - Split mode: low half under timer a
// - Split mode: high half timer, timer b run
// - Timer b mode 11 holds its count
// - Trigger type 0 low level, 1 falling
// - Timer increments once per twelve clocks
// - Counter increments on sampled high-to-low
// - 13-bit mode: prescale by 32, 8-bit count
`timescale 1ns/100ps
module tcf_timer_ctrl
    import tcf_pkg::*;
#(
    parameter int unsigned MC_DIV = TCF_MC_OSC_PERIODS
) (
    input wire logic I_CLOCK,
    input wire logic I_RST,
    input wire logic [5:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    input wire logic I_EXT_IRQ_PIN_A,
    input wire logic I_EXT_IRQ_PIN_B,
    input wire logic I_COUNT_PIN_A,
    input wire logic I_COUNT_PIN_B,
    input wire logic I_VECTOR_TIMER_A,
    input wire logic I_VECTOR_TIMER_B,
    input wire logic I_VECTOR_EXT_A,
    input wire logic I_VECTOR_EXT_B,
    output logic O_IRQ,
    output logic [7:0] O_TIMER_CONTROL_FLAGS
);

    // -----------------------------------------------------------------------
    // Elaboration checks
    // -----------------------------------------------------------------------
    // Divider counter is four bits wide
    if (MC_DIV < 2 || MC_DIV > 16) begin : g_bad_div
        $error("MC_DIV must lie between 2 and 16");
    end

    localparam logic [3:0] MC_LAST = 4'(MC_DIV - 1);

    // -----------------------------------------------------------------------
    // Step function shared by both timers for modes 0 to 2
    // -----------------------------------------------------------------------
    // Returns overflow in bit 16 and the new count below it
    function automatic logic [16:0] tmr_step(input logic [15:0] c,
                                             input tcf_mode_e m,
                                             input logic inc);
        logic [13:0] s13;
        logic [16:0] s16;
        logic [8:0] s8;
        logic [16:0] res;
        s13 = {1'b0, c[15:8], c[4:0]} + 14'h0001;
        s16 = {1'b0, c} + 17'h0_0001;
        s8 = {1'b0, c[7:0]} + 9'h001;
        res = {1'b0, c};
        if (inc) begin
            case (m)
                // Prescaler in low five bits, eight-bit count above
                TCF_MODE_13BIT: res = {s13[13], s13[12:5], c[7:5],
                                       s13[4:0]};
                TCF_MODE_16BIT: res = s16;
                // Low byte reloads from high byte on overflow
                TCF_MODE_RELOAD8: begin
                    res = s8[8] ? {1'b1, c[15:8], c[15:8]}
                                : {1'b0, c[15:8], s8[7:0]};
                end
                default: res = {1'b0, c};
            endcase
        end
        return res;
    endfunction : tmr_step

    // -----------------------------------------------------------------------
    // State
    // -----------------------------------------------------------------------
    logic wait_r, wait_nxt; // Waitrequest, high while idle
    logic [31:0] rdata_r, rdata_nxt; // Read data of current access
    logic [3:0] mc_cnt_r, mc_cnt_nxt; // Machine cycle divider
    logic mc_tick; // One-cycle machine cycle enable
    logic [3:0] samp_r, samp_nxt; // Previous pin samples
    tcf_timer_control_flags_s timer_control_flags_r, timer_control_flags_nxt; // Control flags
    tcf_timer_mode_select_s timer_mode_select_r, timer_mode_select_nxt; // Mode select
    logic [15:0] cnt_a_r, cnt_a_nxt; // Timer a, high and low byte
    logic [15:0] cnt_b_r, cnt_b_nxt; // Timer b
    logic [3:0] ists_r, ists_nxt; // Sticky interrupt status
    logic [3:0] ien_r, ien_nxt; // Interrupt enables
    logic irq_r, irq_nxt; // Interrupt output
    tcf_av_req_s req; // Bundled bus request

    // -----------------------------------------------------------------------
    // Next-state logic
    // -----------------------------------------------------------------------
    always_comb begin
        logic acc; // Access completes this edge
        logic wr_lo; // Write touching byte lane 0
        logic run_a, run_b, inc_a, inc_b, inc_hi;
        logic fall_ta, fall_tb, fall_xa, fall_xb;
        logic ovf_a, ovf_b, set_ia, set_ib;
        logic [16:0] st_a, st_b;
        logic [8:0] lo_s, hi_s;
        logic [7:0] tc;
        logic [3:0] ev;
        acc = 1'b0;
        wr_lo = 1'b0;
        run_a = 1'b0;
        run_b = 1'b0;
        inc_a = 1'b0;
        inc_b = 1'b0;
        inc_hi = 1'b0;
        fall_ta = 1'b0;
        fall_tb = 1'b0;
        fall_xa = 1'b0;
        fall_xb = 1'b0;
        ovf_a = 1'b0;
        ovf_b = 1'b0;
        set_ia = 1'b0;
        set_ib = 1'b0;
        st_a = 17'h0_0000;
        st_b = 17'h0_0000;
        lo_s = 9'h000;
        hi_s = 9'h000;
        tc = timer_control_flags_r;
        ev = 4'h0;
        req = '{read: I_AVS_READ, write: I_AVS_WRITE, addr: I_AVS_ADDRESS,
                wdata: I_AVS_WRITEDATA, be: I_AVS_BYTEENABLE};
        wait_nxt = 1'b1;
        rdata_nxt = rdata_r;
        mc_cnt_nxt = mc_tick ? 4'h0 : mc_cnt_r + 4'h1;
        samp_nxt = samp_r;
        timer_mode_select_nxt = timer_mode_select_r;
        cnt_a_nxt = cnt_a_r;
        cnt_b_nxt = cnt_b_r;
        ien_nxt = ien_r;
        ists_nxt = ists_r;

        // Bus: answer one cycle after the request appears
        if ((req.read || req.write) && wait_r) begin
            wait_nxt = 1'b0;
            rdata_nxt = 32'h0000_0000;
            case (req.addr)
                TCF_OFF_CTRL: rdata_nxt[7:0] = timer_control_flags_r;
                TCF_OFF_MODE: rdata_nxt[7:0] = timer_mode_select_r;
                TCF_OFF_CNT_A: rdata_nxt[15:0] = cnt_a_r;
                TCF_OFF_CNT_B: rdata_nxt[15:0] = cnt_b_r;
                TCF_OFF_IRQ_STAT: rdata_nxt[3:0] = ists_r;
                TCF_OFF_IRQ_EN: rdata_nxt[3:0] = ien_r;
                // Unmapped and write-only offsets read as zero
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
        acc = (req.read || req.write) && !wait_r;
        wr_lo = acc && req.write && req.be[0];

        // Software side of registers, overridden below by hardware sets
        if (wr_lo) begin
            case (req.addr)
                TCF_OFF_CTRL: tc = req.wdata[7:0];
                // Single bit write: index and value in lane 0
                TCF_OFF_BITWR: tc[req.wdata[TCF_BITWR_IDX_LSB +: 3]] =
                    req.wdata[TCF_BITWR_VAL_POS];
                // Only a whole-byte write reaches the mode register
                TCF_OFF_MODE: timer_mode_select_nxt = req.wdata[7:0];
                TCF_OFF_IRQ_EN: ien_nxt = req.wdata[3:0];
                default: ;
            endcase
        end

        // Sampling of count and interrupt pins once per machine cycle
        if (mc_tick) begin
            fall_ta = samp_r[0] && !I_COUNT_PIN_A;
            fall_tb = samp_r[1] && !I_COUNT_PIN_B;
            fall_xa = samp_r[2] && !I_EXT_IRQ_PIN_A;
            fall_xb = samp_r[3] && !I_EXT_IRQ_PIN_B;
            samp_nxt = {I_EXT_IRQ_PIN_B, I_EXT_IRQ_PIN_A,
                        I_COUNT_PIN_B, I_COUNT_PIN_A};
        end

        // Run condition: run bit, gated by pin when gate is set
        run_a = timer_control_flags_r.timer_a_run &&
                (!timer_mode_select_r.a.gate || I_EXT_IRQ_PIN_A);
        run_b = timer_control_flags_r.timer_b_run &&
                (!timer_mode_select_r.b.gate || I_EXT_IRQ_PIN_B);
        inc_a = run_a && (timer_mode_select_r.a.cnt_ext ? fall_ta : mc_tick);
        inc_b = run_b && (timer_mode_select_r.b.cnt_ext ? fall_tb : mc_tick);

        // Timer a, including the split mode
        if (timer_mode_select_r.a.mode == TCF_MODE_SPLIT) begin
            lo_s = {1'b0, cnt_a_r[7:0]} + 9'h001;
            hi_s = {1'b0, cnt_a_r[15:8]} + 9'h001;
            inc_hi = timer_control_flags_r.timer_b_run && mc_tick;
            if (inc_a) begin
                cnt_a_nxt[7:0] = lo_s[7:0];
            end
            if (inc_hi) begin
                cnt_a_nxt[15:8] = hi_s[7:0];
            end
            ovf_a = inc_a && lo_s[8];
        end else begin
            st_a = tmr_step(cnt_a_r, timer_mode_select_r.a.mode, inc_a);
            cnt_a_nxt = st_a[15:0];
            ovf_a = st_a[16];
        end

        // Timer b; split mode on b stops it in place
        if (timer_mode_select_r.b.mode != TCF_MODE_SPLIT) begin
            st_b = tmr_step(cnt_b_r, timer_mode_select_r.b.mode, inc_b);
            cnt_b_nxt = st_b[15:0];
        end
        // While timer a is split, its high half owns timer b's flag
        ovf_b = (timer_mode_select_r.a.mode == TCF_MODE_SPLIT) ? (inc_hi && hi_s[8])
                                                   : st_b[16];

        // Software writes to the counts win over the increment
        if (acc && req.write && req.addr == TCF_OFF_CNT_A) begin
            if (req.be[0]) cnt_a_nxt[7:0] = req.wdata[7:0];
            if (req.be[1]) cnt_a_nxt[15:8] = req.wdata[15:8];
        end
        if (acc && req.write && req.addr == TCF_OFF_CNT_B) begin
            if (req.be[0]) cnt_b_nxt[7:0] = req.wdata[7:0];
            if (req.be[1]) cnt_b_nxt[15:8] = req.wdata[15:8];
        end

        // Overflow flags: vector clears, overflow sets and wins
        timer_control_flags_nxt = tc;
        if (I_VECTOR_TIMER_A) timer_control_flags_nxt.timer_a_overflow_flag = 1'b0;
        if (I_VECTOR_TIMER_B) timer_control_flags_nxt.timer_b_overflow_flag = 1'b0;
        if (ovf_a) timer_control_flags_nxt.timer_a_overflow_flag = 1'b1;
        if (ovf_b) timer_control_flags_nxt.timer_b_overflow_flag = 1'b1;

        // External flags: type 1 falling edge, type 0 follows low level
        if (timer_control_flags_r.ext_irq_a_trigger_type) begin
            set_ia = fall_xa;
            if (I_VECTOR_EXT_A) timer_control_flags_nxt.ext_irq_a_flag = 1'b0;
        end else if (mc_tick) begin
            set_ia = !I_EXT_IRQ_PIN_A;
            timer_control_flags_nxt.ext_irq_a_flag = 1'b0;
        end
        if (timer_control_flags_r.ext_irq_b_trigger_type) begin
            set_ib = fall_xb;
            if (I_VECTOR_EXT_B) timer_control_flags_nxt.ext_irq_b_flag = 1'b0;
        end else if (mc_tick) begin
            set_ib = !I_EXT_IRQ_PIN_B;
            timer_control_flags_nxt.ext_irq_b_flag = 1'b0;
        end
        if (set_ia) timer_control_flags_nxt.ext_irq_a_flag = 1'b1;
        if (set_ib) timer_control_flags_nxt.ext_irq_b_flag = 1'b1;

        // Sticky status: write-one clear, a new event wins
        ev[TCF_IRQ_TMR_A] = ovf_a;
        ev[TCF_IRQ_TMR_B] = ovf_b;
        ev[TCF_IRQ_EXT_A] = set_ia && !timer_control_flags_r.ext_irq_a_flag;
        ev[TCF_IRQ_EXT_B] = set_ib && !timer_control_flags_r.ext_irq_b_flag;
        if (wr_lo && req.addr == TCF_OFF_IRQ_CLR) begin
            ists_nxt = ists_nxt & ~req.wdata[3:0];
        end
        ists_nxt = ists_nxt | ev;
        // Registered, so the line trails the status by one cycle
        irq_nxt = |(ists_r & ien_r);
    end

    // Machine cycle enable from the divider
    assign mc_tick = (mc_cnt_r == MC_LAST);

    // -----------------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------------
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
            mc_cnt_r <= 4'h0;
            samp_r <= 4'hf;
            timer_control_flags_r <= TCF_CTRL_RST;
            timer_mode_select_r <= TCF_MODE_RST;
            cnt_a_r <= TCF_CNT_RST;
            cnt_b_r <= TCF_CNT_RST;
            ists_r <= TCF_IRQ_RST;
            ien_r <= TCF_IRQ_RST;
            irq_r <= 1'b0;
        end else begin
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
            mc_cnt_r <= mc_cnt_nxt;
            samp_r <= samp_nxt;
            timer_control_flags_r <= timer_control_flags_nxt;
            timer_mode_select_r <= timer_mode_select_nxt;
            cnt_a_r <= cnt_a_nxt;
            cnt_b_r <= cnt_b_nxt;
            ists_r <= ists_nxt;
            ien_r <= ien_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign O_AVS_READDATA = rdata_r;
    assign O_AVS_WAITREQUEST = wait_r;
    assign O_IRQ = irq_r;
    assign O_TIMER_CONTROL_FLAGS = timer_control_flags_r;

endmodule : tcf_timer_ctrl

// ===== src/tcf_pkg.sv
// ---------------------------------------------------------------------------
// Shared constants and types of the timer control block
// ---------------------------------------------------------------------------
package tcf_pkg;
    // Clock and machine cycle
    localparam int unsigned TCF_CLK_HZ = 20_000_000;
    localparam int unsigned TCF_MC_OSC_PERIODS = 12;
    // Register byte offsets
    localparam logic [5:0] TCF_OFF_CTRL = 6'h00;
    localparam logic [5:0] TCF_OFF_MODE = 6'h04;
    localparam logic [5:0] TCF_OFF_BITWR = 6'h08;
    localparam logic [5:0] TCF_OFF_CNT_A = 6'h10;
    localparam logic [5:0] TCF_OFF_CNT_B = 6'h14;
    localparam logic [5:0] TCF_OFF_IRQ_STAT = 6'h20;
    localparam logic [5:0] TCF_OFF_IRQ_CLR = 6'h24;
    localparam logic [5:0] TCF_OFF_IRQ_EN = 6'h28;
    // Reset values
    localparam logic [7:0] TCF_CTRL_RST = 8'h00;
    localparam logic [7:0] TCF_MODE_RST = 8'h00;
    localparam logic [15:0] TCF_CNT_RST = 16'h0000;
    localparam logic [3:0] TCF_IRQ_RST = 4'h0;
    // Bit-write register fields
    localparam int unsigned TCF_BITWR_IDX_LSB = 0;
    localparam int unsigned TCF_BITWR_VAL_POS = 3;
    // Interrupt status bit positions
    localparam int unsigned TCF_IRQ_TMR_A = 0;
    localparam int unsigned TCF_IRQ_TMR_B = 1;
    localparam int unsigned TCF_IRQ_EXT_A = 2;
    localparam int unsigned TCF_IRQ_EXT_B = 3;

    // Operating modes of one timer
    typedef enum logic [1:0] {
        TCF_MODE_13BIT = 2'h0,
        TCF_MODE_16BIT = 2'h1,
        TCF_MODE_RELOAD8 = 2'h2,
        TCF_MODE_SPLIT = 2'h3
    } tcf_mode_e;

    // One timer's nibble of the mode register
    typedef struct packed {
        logic gate;
        logic cnt_ext;
        tcf_mode_e mode;
    } tcf_tmode_s;

    // Whole mode register, timer b in the upper nibble
    typedef struct packed {
        tcf_tmode_s b;
        tcf_tmode_s a;
    } tcf_timer_mode_select_s;

    // Control flags register, bit 7 first
    typedef struct packed {
        logic timer_b_overflow_flag;
        logic timer_b_run;
        logic timer_a_overflow_flag;
        logic timer_a_run;
        logic ext_irq_b_flag;
        logic ext_irq_b_trigger_type;
        logic ext_irq_a_flag;
        logic ext_irq_a_trigger_type;
    } tcf_timer_control_flags_s;

    // One Avalon-MM request as seen by the slave
    typedef struct packed {
        logic read;
        logic write;
        logic [5:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
    } tcf_av_req_s;
endpackage : tcf_pkg

// ===== sim/tcf_pin_model.sv
`timescale 1ns/100ps
// --------------------------------------------------
// Far side: count inputs and interrupt pins
// --------------------------------------------------
module tcf_pin_model (
    input wire logic i_clock,
    output logic [3:0] o_pins
);
    // Pin order: count a, count b, irq a, irq b; idle high like port lines
    initial o_pins = 4'hF;
    // Move one pin just after an edge
    task automatic drive(input int k, input logic v);
        @(posedge i_clock);
        o_pins[k] <= v;
    endtask : drive
    // Each level stands four clocks, so any divider up to 4 samples it
    task automatic pulse(input int k, input int n);
        repeat (n) begin
            drive(k, 1'b0);
            repeat (3) @(posedge i_clock);
            drive(k, 1'b1);
            repeat (3) @(posedge i_clock);
        end
    endtask : pulse
endmodule : tcf_pin_model

// ===== sim/tcf_timer_ctrl_properties.sv
`timescale 1ns/100ps
// --------------------------------------------------
// Port checker of the timer control block
// --------------------------------------------------
module tcf_chk (
    input wire logic I_CLOCK,
    input wire logic I_RST,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic I_EXT_IRQ_PIN_A,
    input wire logic I_VECTOR_TIMER_A,
    input wire logic I_VECTOR_TIMER_B,
    input wire logic [31:0] O_AVS_READDATA,
    input wire logic O_AVS_WAITREQUEST,
    input wire logic [7:0] O_TIMER_CONTROL_FLAGS
);
    // One domain; reset aborts every attempt
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (I_RST);
    // Short alias; flags copy may lag one clock, hence two-cycle windows
    wire [7:0] f = O_TIMER_CONTROL_FLAGS;
    a_wait_single: assert property (
        !O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST) else $error("wait low twice");
    a_bus_answer: assert property (
        (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST
    ) else $error("access not answered");
    a_rdata_hold: assert property (
        O_AVS_WAITREQUEST |-> $stable(O_AVS_READDATA)) else $error("rdata moved");
    a_vec_clr_a: assert property (
        I_VECTOR_TIMER_A && !I_AVS_WRITE && !f[4] |-> ##[1:2] !f[5]
    ) else $error("timer a flag kept after vector");
    a_vec_clr_b: assert property (
        I_VECTOR_TIMER_B && !I_AVS_WRITE && !f[6] |-> ##[1:2] !f[7]
    ) else $error("timer b flag kept after vector");
    a_run_by_sw: assert property (
        $changed(f[6]) || $changed(f[4])
            |-> $past(I_AVS_WRITE) || $past(I_AVS_WRITE, 2)
    ) else $error("run bit moved without a write");
    a_ovf_run: assert property (
        $rose(f[5]) && !$past(I_AVS_WRITE) && !$past(I_AVS_WRITE, 2)
            |-> $past(f[4]) || $past(f[4], 2)
    ) else $error("timer a overflow while stopped");
    a_ext_low: assert property (
        $rose(f[1]) && !$past(I_AVS_WRITE) && !$past(I_AVS_WRITE, 2)
            |-> !$past(I_EXT_IRQ_PIN_A) || !$past(I_EXT_IRQ_PIN_A, 2)
    ) else $error("irq a flag set with pin high");
endmodule : tcf_chk

bind tcf_timer_ctrl tcf_chk u_chk (
    .I_CLOCK(I_CLOCK),
    .I_RST(I_RST),
    .I_AVS_READ(I_AVS_READ),
    .I_AVS_WRITE(I_AVS_WRITE),
    .I_EXT_IRQ_PIN_A(I_EXT_IRQ_PIN_A),
    .I_VECTOR_TIMER_A(I_VECTOR_TIMER_A),
    .I_VECTOR_TIMER_B(I_VECTOR_TIMER_B),
    .O_AVS_READDATA(O_AVS_READDATA),
    .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
    .O_TIMER_CONTROL_FLAGS(O_TIMER_CONTROL_FLAGS)
);

// ===== sim/tb.sv
`timescale 1ns/100ps
// --------------------------------------------------
// Self-checking bench of the timer control block
// --------------------------------------------------
module tb
    import tcf_pkg::*;
;
    // Row: timer, mode nibble, load, count after three edges, overflow
    typedef struct packed {
        logic sel;
        logic [3:0] nib;
        logic [15:0] load;
        logic [15:0] exp;
        logic ovf;
    } tcf_row_s;
    tcf_row_s rows [5] = '{
        '{1'b0, 4'h4, 16'hFF1E, 16'h0001, 1'b1},
        '{1'b0, 4'h5, 16'hFFFE, 16'h0001, 1'b1},
        '{1'b0, 4'h6, 16'hF0FE, 16'hF0F1, 1'b1},
        '{1'b1, 4'h5, 16'h1234, 16'h1237, 1'b0},
        '{1'b1, 4'h6, 16'h80FF, 16'h8082, 1'b1}
    };
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [5:0] adr = 6'h00;
    logic [31:0] wd = 32'h0000_0000;
    logic [3:0] vec = 4'h0; // Vectors: ovf a, ovf b, irq a, irq b
    logic [3:0] pins;
    logic [31:0] rdata;
    logic wreq;
    logic irq;
    logic [7:0] flags;
    logic [31:0] q;
    logic s;
    logic [5:0] co;
    logic [7:0] e;
    int n;
    int bad_count = 0;
    int checks_done = 0;
    // Clock: 50 ns
    initial begin
        forever #25 clk = ~clk;
    end
    // Divider of 2 keeps the machine cycle short
    tcf_timer_ctrl #(.MC_DIV(2)) DUT (
        .I_CLOCK(clk),
        .I_RST(rst),
        .I_AVS_ADDRESS(adr),
        .I_AVS_READ(rd),
        .I_AVS_WRITE(wr),
        .I_AVS_WRITEDATA(wd),
        .I_AVS_BYTEENABLE(4'hF),
        .O_AVS_READDATA(rdata),
        .O_AVS_WAITREQUEST(wreq),
        .I_EXT_IRQ_PIN_A(pins[2]),
        .I_EXT_IRQ_PIN_B(pins[3]),
        .I_COUNT_PIN_A(pins[0]),
        .I_COUNT_PIN_B(pins[1]),
        .I_VECTOR_TIMER_A(vec[0]),
        .I_VECTOR_TIMER_B(vec[1]),
        .I_VECTOR_EXT_A(vec[2]),
        .I_VECTOR_EXT_B(vec[3]),
        .O_IRQ(irq),
        .O_TIMER_CONTROL_FLAGS(flags)
    );
    tcf_pin_model pm (
        .i_clock(clk),
        .o_pins(pins)
    );
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checks_done++;
        if (got !== want) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : chk
    // Bus access held until waitrequest is sampled low
    task automatic acc(input logic w, input logic [5:0] a,
                       input logic [15:0] d);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= {16'h0000, d};
        // Look between edges, so the edge that launches waitrequest
        // never races this test; only the watchdog ends a hang
        do begin
            @(negedge clk);
        end while (wreq !== 1'b0);
        // The next rising edge samples waitrequest low and takes it
        @(posedge clk);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask : acc
    // One-clock vector pulse
    task automatic vpulse(input int k);
        vec[k] <= 1'b1;
        @(posedge clk);
        vec[k] <= 1'b0;
        @(posedge clk);
    endtask : vpulse
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize
    // Watchdog: the run needs about 450 clocks
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({22'h0, irq, wreq, flags}, {22'h0, 2'b01, TCF_CTRL_RST});
        acc(0, TCF_OFF_MODE, 16'h0000);
        chk(q, {24'h0, TCF_MODE_RST});
        acc(1, 6'h3C, 16'h00FF); // Unmapped write is dropped
        acc(0, 6'h3C, 16'h0000);
        chk(q, 32'h0000_0000);
        foreach (rows[i]) begin
            s = rows[i].sel;
            co = s ? TCF_OFF_CNT_B : TCF_OFF_CNT_A;
            e = s ? {rows[i].ovf, 7'h40} : {2'b00, rows[i].ovf, 5'h10};
            acc(1, TCF_OFF_MODE, s ? {8'h00, rows[i].nib, 4'h0}
                                   : {12'h000, rows[i].nib});
            acc(1, co, rows[i].load);
            acc(1, TCF_OFF_BITWR, {12'h000, 2'b11, s, 1'b0});
            pm.pulse(int'(s), 3);
            acc(0, TCF_OFF_CTRL, 16'h0000);
            chk(q, {24'h0, e});
            acc(1, TCF_OFF_BITWR, {12'h000, 2'b01, s, 1'b0});
            vpulse(int'(s));
            acc(0, TCF_OFF_CTRL, 16'h0000);
            chk(q, 32'h0000_0000);
            acc(0, co, 16'h0000);
            chk(q, {16'h0000, rows[i].exp});
        end
        // Split: high half runs on timer b's run bit alone
        acc(1, TCF_OFF_MODE, 16'h0033);
        acc(1, TCF_OFF_CNT_A, 16'hFE00);
        acc(1, TCF_OFF_CNT_B, 16'h1234);
        acc(1, TCF_OFF_BITWR, 16'h000E);
        n = 0;
        while (flags[7] !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n >= 100) bad_count++;
        acc(0, TCF_OFF_CTRL, 16'h0000);
        chk(q, 32'h0000_00C0);
        acc(1, TCF_OFF_CTRL, 16'h0000);
        acc(0, TCF_OFF_CNT_A, 16'h0000);
        chk({24'h0, q[7:0]}, 32'h0000_0000);
        acc(0, TCF_OFF_CNT_B, 16'h0000);
        chk(q, 32'h0000_1234);
        // Gated timer a: frozen while its pin is low
        acc(1, TCF_OFF_MODE, 16'h0009);
        acc(1, TCF_OFF_CNT_A, 16'h0000);
        pm.drive(2, 1'b0);
        acc(1, TCF_OFF_BITWR, 16'h000C);
        repeat (20) @(posedge clk);
        acc(0, TCF_OFF_CNT_A, 16'h0000);
        chk(q, 32'h0000_0000);
        pm.drive(2, 1'b1);
        repeat (20) @(posedge clk);
        acc(0, TCF_OFF_CNT_A, 16'h0000);
        chk({31'h0, q !== 32'h0000_0000}, 32'h0000_0001);
        acc(1, TCF_OFF_CTRL, 16'h0001); // Stop, irq a on falling edge
        acc(1, TCF_OFF_IRQ_CLR, 16'h000F);
        acc(1, TCF_OFF_IRQ_EN, 16'h0004);
        pm.pulse(2, 1);
        acc(0, TCF_OFF_IRQ_STAT, 16'h0000);
        chk({23'h0, irq, q[7:0]}, 32'h0000_0104);
        vpulse(2);
        acc(0, TCF_OFF_CTRL, 16'h0000);
        chk(q, 32'h0000_0001);
        acc(1, TCF_OFF_IRQ_CLR, 16'h0004);
        acc(0, TCF_OFF_IRQ_STAT, 16'h0000);
        chk({23'h0, irq, q[7:0]}, 32'h0000_0000);
        // Falling edge on irq b pin sets its flag; vector clears it
        acc(1, TCF_OFF_CTRL, 16'h0004);
        pm.pulse(3, 1);
        acc(0, TCF_OFF_CTRL, 16'h0000);
        chk(q, 32'h0000_000C);
        vpulse(3);
        acc(0, TCF_OFF_CTRL, 16'h0000);
        chk(q, 32'h0000_0004);
        // Low level: flag follows the pin, vector leaves it, irq masked
        acc(1, TCF_OFF_CTRL, 16'h0000);
        acc(1, TCF_OFF_IRQ_EN, 16'h0000);
        pm.drive(2, 1'b0);
        repeat (8) @(posedge clk);
        vpulse(2);
        acc(0, TCF_OFF_CTRL, 16'h0000);
        chk({23'h0, irq, q[7:0]}, 32'h0000_0002);
        pm.drive(2, 1'b1);
        repeat (8) @(posedge clk);
        acc(0, TCF_OFF_CTRL, 16'h0000);
        chk(q, 32'h0000_0000);
        // Mid-run reset: flags and mode fall back to their reset values
        acc(1, TCF_OFF_CTRL, 16'h0055);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({22'h0, irq, wreq, flags}, {22'h0, 2'b01, TCF_CTRL_RST});
        acc(0, TCF_OFF_MODE, 16'h0000);
        chk(q, {24'h0, TCF_MODE_RST});
        summarize();
    end
endmodule : tb
